//--- i2c_wiper_register_slave.sv
// serial bus slave holding the wiper, initial-value and access control registers
//
// Contract
// - wiper code 00h is nearest the low terminal, 7Fh the high, monotonic between
// - power-up presets wiper to 40h, then reloads it from the initial-value store
// - address 0 is store/wiper pair, 1 reserved, 2 access control
// - volatile-select bit 7 routes address 0: 0 store, 1 wiper only; default 0
// - writing the initial-value store also writes the wiper register
// - access control bit 6 is shutdown control, default 1, 0 shuts down
// - normal only when shutdown pin high and control bit 1; registers stay reachable
// - access control bit 5 reads 1 while a stored write runs
// - while write-in-progress, writes to wiper and access control are rejected
// - slave only: never starts transfers, never drives the serial clock
// - bytes move most significant bit first both ways
// - data changes with clock low; data edges with clock high are start/stop
// - data pin released after power-up; starts ignored until power-up done
// - a stop returns the interface to idle
// - receiver pulls data low on ninth clock; transmitter releases after eighth bit
// - acknowledge valid id byte, address byte and each write data byte
// - id byte is 01010, two address pin levels, then direction bit
// - stored write starts at stop, lasts up to 20ms, flag set meanwhile
// - device sends bytes while master acknowledges; master ends with stop
`timescale 1ns/1ns
`default_nettype none
module i2c_wiper_register_slave
	import wiper_pkg::*;
#(
	parameter int NV_WRITE_CYCLES = NV_WRITE_CYC_DEF
) (
	// clock and power-up reset
	input  wire logic       clk,
	input  wire logic       rst,
	// serial bus pins, data is open drain
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// strap and control pins
	input  wire logic       addr_pin_hi,
	input  wire logic       addr_pin_lo,
	input  wire logic       shutdown_pin_n,
	// potentiometer side
	output logic [6:0]      wiper_code,
	output logic            shutdown_active,
	output logic            write_in_progress
);
	// ************************************************************
	// declarations
	// ************************************************************
	localparam int TW = $clog2(NV_WRITE_CYCLES + 1);
	localparam int LW = $clog2(POWERUP_CYCLES + 1);

	logic [SYNC_W-1:0] pins_s;
	logic              scl_s;
	logic              sda_s;
	logic              scl_p_q;
	logic              sda_p_q;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_det;
	logic              stop_det;
	logic              byte_end;
	logic              id_ok;
	logic              rx_state;
	logic              cnt_state;
	logic              wr_fire;
	logic              wr_allow;
	logic              load_done;
	logic [7:0]        acc_rd;
	logic [7:0]        rd_data;
	logic [7:0]        byte_rx;
	bus_state_t        state_q;
	bus_state_t        state_d;
	logic [3:0]        cnt_q;
	logic [7:0]        sh_q;
	logic [7:0]        tx_q;
	logic [7:0]        ptr_q;
	logic              rw_q;
	logic              more_q;
	logic              ready_q;
	logic [LW-1:0]     load_cnt_q;
	logic [7:0]        wiper_q;
	logic [7:0]        store_q;
	logic              vol_q;
	logic              shutdown_control_q;
	logic              wip_q;
	logic              nv_pend_q;
	logic [TW-1:0]     nv_cnt_q;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	pin_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RESET)
	) u_sync (
		.clk     (clk),
		.rst     (rst),
		.async_i ({addr_pin_lo, addr_pin_hi, shutdown_pin_n, sda_i, scl_i}),
		.sync_o  (pins_s)
	);

	assign scl_s = pins_s[PIN_SCL];
	assign sda_s = pins_s[PIN_SDA];

	// previous samples for edge and condition detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// ************************************************************
	// bus event decode
	// ************************************************************
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	// a data edge while the clock stays high is a start or stop condition
	assign start_det = ready_q & scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = ready_q & scl_s & scl_p_q & ~sda_p_q & sda_s;
	// gated by the counting states so the ack clock's fall still clears the count
	assign byte_end  = scl_fall & (cnt_q == 4'h8) & cnt_state;
	assign byte_rx   = sh_q;
	assign id_ok     = (sh_q[7:3] == ID_PREFIX)
		& (sh_q[2:1] == {pins_s[PIN_ADDR_HI], pins_s[PIN_ADDR_LO]});
	assign rx_state  = (state_q == ST_ID) | (state_q == ST_ADDR) | (state_q == ST_WDATA);
	assign cnt_state = rx_state | (state_q == ST_RDATA);
	assign wr_fire   = (state_q == ST_WDATA) & byte_end;
	assign wr_allow  = wr_fire & ~wip_q;

	// ************************************************************
	// register read path
	// ************************************************************
	assign acc_rd  = {vol_q, shutdown_control_q, wip_q, ACC_LOW_ZERO};
	// address 0 is routed by the volatile-select bit, reserved reads zero
	assign rd_data = (ptr_q == REG_ADDR_WIPER)  ? (vol_q ? wiper_q : store_q) :
		(ptr_q == REG_ADDR_ACCESS) ? acc_rd : 8'h00;

	// ************************************************************
	// bus state machine
	// ************************************************************
	always_comb begin
		state_d = state_q;
		if (!ready_q) begin
			state_d = ST_IDLE;
		end else if (start_det) begin
			state_d = ST_ID;
		end else if (stop_det) begin
			state_d = ST_IDLE;
		end else begin
			case (state_q)
				ST_ID: begin
					if (byte_end) begin
						state_d = id_ok ? ST_ID_ACK : ST_IGNORE;
					end
				end
				ST_ID_ACK: begin
					if (scl_fall) begin
						state_d = rw_q ? ST_RDATA : ST_ADDR;
					end
				end
				ST_ADDR: begin
					if (byte_end) begin
						state_d = ST_ADDR_ACK;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						state_d = ST_WDATA;
					end
				end
				ST_WDATA: begin
					if (byte_end) begin
						state_d = ST_WDATA_ACK;
					end
				end
				ST_WDATA_ACK: begin
					if (scl_fall) begin
						state_d = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (byte_end) begin
						state_d = ST_RACK;
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						state_d = more_q ? ST_RDATA : ST_IGNORE;
					end
				end
				ST_IDLE, ST_IGNORE: begin
					state_d = state_q;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ************************************************************
	// bit counter, shifters and transfer context
	// ************************************************************
	// bits counted on rising clock; byte handled at the falling edge after bit 8
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
		end else if (start_det || (state_d != state_q && !byte_end)) begin
			cnt_q <= 4'h0;
		end else if (scl_rise && cnt_state) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// receive shift, most significant bit first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sh_q <= 8'h00;
		end else if (scl_rise && rx_state) begin
			sh_q <= {sh_q[6:0], sda_s};
		end
	end

	// transmit shift: load on entering a data byte, advance on each falling clock except the one that ends the byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_q <= 8'hff;
		end else if (state_d == ST_RDATA && state_q != ST_RDATA) begin
			tx_q <= rd_data;
		end else if (state_q == ST_RDATA && scl_fall && !byte_end) begin
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// direction, register pointer and master acknowledge capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rw_q   <= 1'b0;
			ptr_q  <= REG_ADDR_WIPER;
			more_q <= 1'b0;
		end else begin
			if (state_q == ST_ID && byte_end) begin
				rw_q <= byte_rx[0];
			end
			if (state_q == ST_ADDR && byte_end) begin
				ptr_q <= byte_rx;
			end
			if (state_q == ST_RACK && scl_rise) begin
				more_q <= ~sda_s;
			end
		end
	end

	// ************************************************************
	// power-up sequence
	// ************************************************************
	// the reload waits until stored data is readable, and the bus waits too
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			load_cnt_q <= LW'(POWERUP_CYCLES);
			ready_q    <= 1'b0;
		end else if (load_cnt_q != '0) begin
			load_cnt_q <= load_cnt_q - LW'(1);
			ready_q    <= (load_cnt_q == LW'(1));
		end
	end

	assign load_done = (load_cnt_q == LW'(1));

	// ************************************************************
	// register file
	// ************************************************************
	// wiper reload at power-up, direct or mirrored writes afterwards
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wiper_q <= WIPER_RESET;
		end else if (load_done) begin
			wiper_q <= store_q;
		end else if (wr_allow && ptr_q == REG_ADDR_WIPER) begin
			wiper_q <= byte_rx;
		end
	end

	// the store models non-volatile memory; reset only sets its simulation start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			store_q <= STORE_RESET;
		end else if (wr_allow && ptr_q == REG_ADDR_WIPER && !vol_q) begin
			store_q <= byte_rx;
		end
	end

	// access control: only bits 7 and 6 are writable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vol_q  <= VOL_RESET;
			shutdown_control_q <= SHUTDOWN_CONTROL_RESET;
		end else if (wr_allow && ptr_q == REG_ADDR_ACCESS) begin
			vol_q  <= byte_rx[ACC_VOL_BIT];
			shutdown_control_q <= byte_rx[ACC_SHUTDOWN_CONTROL_BIT];
		end
	end

	// ************************************************************
	// self-timed stored write
	// ************************************************************
	// a stored write is only armed by the data byte; it starts on the stop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nv_pend_q <= 1'b0;
			wip_q     <= 1'b0;
			nv_cnt_q  <= '0;
		end else if (stop_det && nv_pend_q) begin
			nv_pend_q <= 1'b0;
			wip_q     <= 1'b1;
			nv_cnt_q  <= TW'(NV_WRITE_CYCLES);
		end else begin
			if (start_det) begin
				nv_pend_q <= 1'b0;
			end else if (wr_allow && ptr_q == REG_ADDR_WIPER && !vol_q) begin
				nv_pend_q <= 1'b1;
			end
			if (wip_q) begin
				nv_cnt_q <= nv_cnt_q - TW'(1);
				wip_q    <= (nv_cnt_q != TW'(1));
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// open drain: only ever pull low; the clock pin has no driver at all
	assign sda_o  = 1'b0;
	assign sda_oe = (state_q == ST_ID_ACK) | (state_q == ST_ADDR_ACK)
		| (state_q == ST_WDATA_ACK) | ((state_q == ST_RDATA) & ~tx_q[7]);
	// higher code moves the wiper toward the high terminal
	assign wiper_code        = wiper_q[6:0];
	assign shutdown_active   = ~(pins_s[PIN_SHUTDOWN_CONTROL_N] & shutdown_control_q);
	assign write_in_progress = wip_q;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_preset_hold: assert property (!ready_q && !load_done |-> wiper_q == WIPER_RESET)
		else $error("wiper not at preset before reload");
	a_reload_store: assert property (load_done |=> wiper_q == $past(store_q) && ready_q)
		else $error("wiper not reloaded from store");
	a_acc_low_zero: assert property (acc_rd[4:0] == 5'h00 && acc_rd[5] == wip_q)
		else $error("access control low bits or flag wrong");
	a_shutdown_gate: assert property (shutdown_active == !(pins_s[PIN_SHUTDOWN_CONTROL_N] && shutdown_control_q))
		else $error("shutdown combination wrong");
	a_wip_blocks: assert property (wr_fire && wip_q |=> $stable(wiper_q) && $stable(vol_q)
		&& $stable(shutdown_control_q))
		else $error("write accepted during stored write");
	a_store_mirror: assert property (wr_allow && ptr_q == REG_ADDR_WIPER && !vol_q
		|=> wiper_q == store_q && nv_pend_q)
		else $error("store write not mirrored to wiper");
	a_stop_starts: assert property (stop_det && nv_pend_q |=> wip_q ##1 wip_q)
		else $error("stored write did not start at stop");
	a_idle_release: assert property (state_q == ST_IDLE || state_q == ST_IGNORE
		|-> !sda_oe)
		else $error("data driven while idle");
	a_drive_clk_low: assert property ($changed(sda_oe) |-> !scl_s)
		else $error("data changed with clock high");
	a_stop_idles: assert property (stop_det |=> state_q == ST_IDLE)
		else $error("stop did not return to idle");

	c_read_more: cover property (state_q == ST_RACK && more_q ##1 state_q == ST_RDATA);
	c_nv_write: cover property (stop_det && nv_pend_q);
	c_bad_id: cover property (state_q == ST_ID ##1 state_q == ST_IGNORE);
	c_reject: cover property (wr_fire && wip_q);
endmodule
`default_nettype wire

//--- wiper_pkg.sv
// shared constants and types for the wiper register serial slave
package wiper_pkg;

	// ************************************************************
	// register map and field layout
	// ************************************************************
	localparam logic [7:0] REG_ADDR_WIPER  = 8'h00;
	localparam logic [7:0] REG_ADDR_RSVD   = 8'h01;
	localparam logic [7:0] REG_ADDR_ACCESS = 8'h02;
	localparam int         ACC_VOL_BIT     = 7;
	localparam int         ACC_SHUTDOWN_CONTROL_BIT    = 6;
	localparam int         ACC_WIP_BIT     = 5;
	localparam logic [4:0] ACC_LOW_ZERO    = 5'h00;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] WIPER_RESET = 8'h40;
	localparam logic [7:0] STORE_RESET = 8'h40;
	localparam logic       VOL_RESET   = 1'b0;
	localparam logic       SHUTDOWN_CONTROL_RESET  = 1'b1;

	// ************************************************************
	// identification byte and pin synchroniser layout
	// ************************************************************
	localparam logic [4:0] ID_PREFIX   = 5'h0a;
	localparam int         SYNC_W      = 5;
	localparam int         PIN_SCL     = 0;
	localparam int         PIN_SDA     = 1;
	localparam int         PIN_SHUTDOWN_CONTROL_N  = 2;
	localparam int         PIN_ADDR_HI = 3;
	localparam int         PIN_ADDR_LO = 4;
	localparam logic [4:0] SYNC_RESET  = 5'h07;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS    = 10;
	localparam int NV_WRITE_NS      = 20_000_000;
	localparam int NV_WRITE_CYC_DEF = NV_WRITE_NS / CLK_PERIOD_NS;
	localparam int POWERUP_NS       = 1000;
	localparam int POWERUP_CYCLES   = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// bus interface states
	// ************************************************************
	typedef enum logic [3:0] {
		ST_IDLE, ST_ID, ST_ID_ACK, ST_ADDR, ST_ADDR_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
	} bus_state_t;

endpackage

//--- pin_sync.sv
// two-flop synchronisers for pins arriving from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// pins in, synchronised levels out
	input  wire logic [W-1:0] async_i,
	output var  logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;

	// one stage pair per pin; the first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				meta_q[i] <= RST_VAL[i];
				sync_o[i] <= RST_VAL[i];
			end else begin
				meta_q[i] <= async_i[i];
				sync_o[i] <= meta_q[i];
			end
		end
	end
endmodule
`default_nettype wire

//--- i2c_master_model.sv
// bus master model that drives the serial clock and pulls the data line
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
	// serial bus, data is open drain with a pull-up outside
	output var  logic scl,
	output var  logic sda_pull,
	input  wire logic sda_line
);
	// ************************************************************
	// bus timing
	// ************************************************************
	localparam int QTR_NS = 40; // quarter of the 160 ns bus period

	// idle bus: clock high and data released
	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	// one bus clock: data set while clock low, sampled while clock high
	task automatic bit_x(input logic v, output logic s);
		scl = 1'b0;
		#QTR_NS sda_pull = ~v;
		#QTR_NS scl = 1'b1;
		#QTR_NS s = sda_line;
		#QTR_NS;
	endtask

	// start or repeated start: data falls while the clock is high
	task automatic start_c();
		scl = 1'b0;
		#QTR_NS sda_pull = 1'b0;
		#QTR_NS scl = 1'b1;
		#(2*QTR_NS) sda_pull = 1'b1;
		#(2*QTR_NS) scl = 1'b0;
	endtask

	// stop: data rises while the clock is high, then the clock stands still
	task automatic stop_c();
		scl = 1'b0;
		#QTR_NS sda_pull = 1'b1;
		#QTR_NS scl = 1'b1;
		#(2*QTR_NS) sda_pull = 1'b0;
		#(2*QTR_NS);
	endtask

	// a byte sent with tx all ones leaves the line to the slave
	task automatic byte_x(input logic [7:0] tx, input logic m_ack,
			output logic [7:0] rx, output logic s_ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(~m_ack, a);
		s_ack = ~a;
	endtask
endmodule
`default_nettype wire

//--- tb_i2c_wiper_register_slave.sv
// self-checking bench for the wiper register serial slave
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_wiper_register_slave import wiper_pkg::*;;
	// ************************************************************
	// signals and instances
	// ************************************************************
	localparam int NV_CYC = 3000; // long enough to fit frames inside it
	localparam int DLY    = 2;    // drive offset after the rising edge

	logic       clk            = 1'b0;
	logic       rst            = 1'b1;
	logic       addr_pin_hi    = 1'b0;
	logic       addr_pin_lo    = 1'b0;
	logic       shutdown_pin_n = 1'b1;
	logic       scl;
	logic       sda_pull;
	logic       sda_o;
	logic       sda_oe;
	logic [6:0] wiper_code;
	logic       shutdown_active;
	logic       write_in_progress;
	logic [7:0] rx;
	logic [7:0] d0;
	logic [7:0] d1;
	logic       ok;
	int         n_fail  = 0;
	int         n_tests = 0;
	int         wip_len = 0;
	int         wip_base = 0;
	// wired-and of both parties; a released line floats up
	wire logic  sda_line = ~(sda_pull | (sda_oe & ~sda_o));

	always #5 clk = ~clk;

	// total clocks spent in stored writes, summed over all of them
	always @(posedge clk) if (write_in_progress === 1'b1) wip_len <= wip_len + 1;

	i2c_master_model i_i2c_master_model (
		.scl      (scl),
		.sda_pull (sda_pull),
		.sda_line (sda_line)
	);

	i2c_wiper_register_slave #(.NV_WRITE_CYCLES(NV_CYC)) i_i2c_wiper_register_slave (
		.clk               (clk),
		.rst               (rst),
		.scl_i             (scl),
		.sda_i             (sda_line),
		.sda_o             (sda_o),
		.sda_oe            (sda_oe),
		.addr_pin_hi       (addr_pin_hi),
		.addr_pin_lo       (addr_pin_lo),
		.shutdown_pin_n    (shutdown_pin_n),
		.wiper_code        (wiper_code),
		.shutdown_active   (shutdown_active),
		.write_in_progress (write_in_progress)
	);

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#DLY;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] id_b(input logic rd);
		return {ID_PREFIX, addr_pin_hi, addr_pin_lo, rd};
	endfunction

	// write frame; ok is high only if all three bytes were acknowledged
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, output logic k);
		logic k0, k1, k2;
		i_i2c_master_model.start_c();
		i_i2c_master_model.byte_x(id_b(1'b0), 1'b0, rx, k0);
		i_i2c_master_model.byte_x(a, 1'b0, rx, k1);
		i_i2c_master_model.byte_x(d, 1'b0, rx, k2);
		i_i2c_master_model.stop_c();
		k = k0 & k1 & k2;
	endtask

	// combined read; with two set the first byte is acknowledged
	task automatic reg_rd(input logic [7:0] a, input logic two, output logic k);
		logic k0, k1, k2, k3;
		i_i2c_master_model.start_c();
		i_i2c_master_model.byte_x(id_b(1'b0), 1'b0, rx, k0);
		i_i2c_master_model.byte_x(a, 1'b0, rx, k1);
		i_i2c_master_model.start_c();
		i_i2c_master_model.byte_x(id_b(1'b1), 1'b0, rx, k2);
		i_i2c_master_model.byte_x(8'hff, two, d0, k3);
		d1 = d0;
		if (two) begin
			i_i2c_master_model.byte_x(8'hff, 1'b0, d1, k3);
		end
		i_i2c_master_model.stop_c();
		k = k0 & k1 & k2;
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		tick(8);
		chk8({1'b0, wiper_code}, 8'h40);
		rst = 1'b0;
		// a frame begun during power-up gets no answer
		tick(5);
		i_i2c_master_model.start_c();
		i_i2c_master_model.byte_x(id_b(1'b0), 1'b0, rx, ok);
		chk1(ok, 1'b0);
		i_i2c_master_model.stop_c();
		tick(20);
		chk8({1'b0, wiper_code}, 8'h40);
		// every strap pair: foreign id refused, own id served
		for (int p = 0; p < 4; p++) begin
			{addr_pin_hi, addr_pin_lo} = 2'(p);
			tick(4);
			i_i2c_master_model.start_c();
			i_i2c_master_model.byte_x({ID_PREFIX ^ 5'(p), ~2'(p), 1'b0}, 1'b0, rx, ok);
			chk1(ok, 1'b0);
			i_i2c_master_model.byte_x(8'h02, 1'b0, rx, ok);
			chk1(ok, 1'b0);
			i_i2c_master_model.stop_c();
			reg_rd(REG_ADDR_ACCESS, 1'b0, ok);
			chk1(ok, 1'b1);
			chk8(d0, 8'h40);
		end
		// stored write, then writes refused while it runs
		wip_base = wip_len;
		reg_wr(REG_ADDR_WIPER, 8'h23, ok);
		chk1(ok, 1'b1);
		chk8({1'b0, wiper_code}, 8'h23);
		chk1(write_in_progress, 1'b1);
		reg_wr(REG_ADDR_ACCESS, 8'h80, ok);
		reg_wr(REG_ADDR_WIPER, 8'h11, ok);
		chk8({1'b0, wiper_code}, 8'h23);
		reg_rd(REG_ADDR_ACCESS, 1'b0, ok);
		chk8(d0, 8'h60);
		for (int i = 0; i < 8 && d0[ACC_WIP_BIT] !== 1'b0; i++) begin
			reg_rd(REG_ADDR_ACCESS, 1'b0, ok);
		end
		chk8(d0, 8'h40);
		chk1(1'(wip_len - wip_base == NV_CYC), 1'b1);
		reg_rd(REG_ADDR_WIPER, 1'b0, ok);
		chk8(d0, 8'h23);
		// pin and control bit table; low bits stay zero
		for (int i = 0; i < 4; i++) begin
			reg_wr(REG_ADDR_ACCESS, {1'b1, 1'(i), 6'h3f}, ok);
			shutdown_pin_n = 1'(i >> 1);
			tick(6);
			chk1(shutdown_active, ~(1'(i >> 1) & 1'(i)));
			reg_rd(REG_ADDR_ACCESS, 1'b0, ok);
			chk8(d0, {1'b1, 1'(i), 6'h00});
		end
		// volatile only path, repeated read of one register
		reg_wr(REG_ADDR_WIPER, 8'h5a, ok);
		chk8({1'b0, wiper_code}, 8'h5a);
		chk1(write_in_progress, 1'b0);
		reg_rd(REG_ADDR_WIPER, 1'b1, ok);
		chk8(d0, 8'h5a);
		chk8(d1, 8'h5a);
		reg_wr(REG_ADDR_ACCESS, 8'h40, ok);
		reg_rd(REG_ADDR_WIPER, 1'b0, ok);
		chk8(d0, 8'h23);
		// reserved and unmapped places
		reg_wr(REG_ADDR_RSVD, 8'h55, ok);
		reg_rd(REG_ADDR_RSVD, 1'b0, ok);
		chk8(d0, 8'h00);
		reg_rd(8'h03, 1'b0, ok);
		chk8(d0, 8'h00);
		reg_rd(REG_ADDR_ACCESS, 1'b0, ok);
		chk8(d0, 8'h40);
		// top code through the volatile path
		reg_wr(REG_ADDR_ACCESS, 8'hc0, ok);
		reg_wr(REG_ADDR_WIPER, 8'hff, ok);
		chk8({1'b0, wiper_code}, 8'h7f);
		print_verdict();
	end
endmodule
`default_nettype wire
